/* hw/sdcal_pkg.sv */
// constants shared by both ends of the calibration link
// assumes one 200 MHz system clock on both ends
package sdcal_pkg;
  // ****************************************
  // clock and modulator timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int MOD_DIV = 128;
  localparam int MOD_CYCLE_NS = MOD_DIV * CLK_PERIOD_NS;
  localparam int MOD_CYCLE_CLKS = MOD_CYCLE_NS / CLK_PERIOD_NS;
  // ****************************************
  // serial frame layout
  // ****************************************
  localparam int CMD_BITS = 8;
  localparam int SETUP_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int CMD_RD_POS = 7;
  localparam int CMD_DATA_POS = 6;
  // ****************************************
  // setup register fields
  // ****************************************
  localparam int MODE_HI_POS = 7;
  localparam int MODE_LO_POS = 6;
  localparam int GAIN_POS = 4;
  localparam int UNI_POS = 3;
  localparam int RATE_POS = 0;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SELF = 2'h1;
  localparam logic [1:0] MODE_SYS_ZS = 2'h2;
  localparam logic [1:0] MODE_SYS_FS = 2'h3;
  // ****************************************
  // calibration timing in output periods
  // ****************************************
  localparam int SYS_STEP_PERIODS = 3;
  localparam int SYS_SETTLE_PERIODS = 1;
  localparam int SELF_STEP_PERIODS = 3;
  localparam int SELF_SETTLE_PERIODS = 3;
  // ****************************************
  // controller register map
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_RDATA = 4'h3;
  localparam logic [1:0] OP_WR_SETUP = 2'h0;
  localparam logic [1:0] OP_RD_SETUP = 2'h1;
  localparam logic [1:0] OP_RD_DATA = 2'h2;
  localparam int OP_POS = 8;
  localparam int ST_XFER_DONE = 0;
  localparam int ST_RESULT = 1;
  localparam int ST_SEQ_ERR = 2;
  localparam int ST_BUSY = 8;
  localparam int ST_ZS_DONE = 9;
  localparam int ST_READY_LVL = 10;
  localparam logic [2:0] MASK_RST = 3'h0;
endpackage

/* hw/cal_link_if.sv */
// four-wire serial link (cs_n, sclk, din, dout) plus result-ready line
// assumes both ends share clk_sys; all wires are push-pull
interface cal_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic result_ready_n;
  modport dev (input cs_n, input sclk, input din, output dout, output result_ready_n);
  modport ctl (output cs_n, output sclk, output din, input dout, input result_ready_n);
endinterface

/* hw/sdcal_device.sv */
// converter end: serial setup port, calibration sequencer, result path
// assumes link inputs are synchronous to clk_sys; the host frames with cs_n
// Contract
// - host writes 1,0 to start zero step
// - host writes 1,1 to start full step
// - step lasts three periods, then mode clears
// - calibration conversions use the selected gain
// - ready line high from start until result
// - one conversion after step, ready at four
// - ready rises within one modulator cycle
// - host ignores ready one modulator cycle
// - host runs zero step first, input steady
// - host holds full-scale input during step
// - bipolar spans midscale to positive full
// - self-cal shorted zero maps to midscale
// - single step updates only its coefficient
// - system cal uses applied inputs as points
// - host writes 0,1 for self-calibration
module sdcal_device #(
  parameter int RATE_BASE_TICKS = 16,
  parameter int GAIN_STEP = 1,
  parameter int FULL_REF = 32767
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // link to the host
  cal_link_if.dev link,
  // analog side, already digitised
  input wire logic signed [15:0] analog_input_pair,
  // status to the user
  output logic [7:0] setup_word,
  output logic [15:0] result_word,
  output logic cal_busy
);
  import sdcal_pkg::*;

  typedef enum {S_IDLE, S_ARM, S_ZERO, S_FULL, S_SETTLE} seq_t;

  // ****************************************
  // modulator divider
  // ****************************************
  logic [6:0] mod_cnt_q;
  logic mod_tick;
  assign mod_tick = (mod_cnt_q == 7'(MOD_DIV - 1));
  // one-cycle enable every modulator cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mod_cnt_q <= 7'h00;
    end else begin
      mod_cnt_q <= mod_cnt_q + 7'h01;
    end
  end

  // ****************************************
  // serial port
  // ****************************************
  logic sclk_q;
  logic rise;
  logic fall;
  logic [4:0] bit_cnt_q;
  logic [7:0] sh_in_q;
  logic [7:0] cmd_q;
  logic [15:0] sh_out_q;
  logic [7:0] in_byte;
  logic cmd_done;
  logic wr_done;
  logic rd_data_done;
  logic [7:0] setup_q;
  logic [15:0] data_q;

  assign rise = link.sclk && !sclk_q;
  assign fall = !link.sclk && sclk_q;
  assign in_byte = {sh_in_q[6:0], link.din};
  assign cmd_done = !link.cs_n && rise && (bit_cnt_q == 5'(CMD_BITS - 1));
  assign wr_done = !link.cs_n && rise && !cmd_q[CMD_RD_POS] && !cmd_q[CMD_DATA_POS]
                   && (bit_cnt_q == 5'(CMD_BITS + SETUP_BITS - 1));
  assign rd_data_done = !link.cs_n && rise && cmd_q[CMD_RD_POS] && cmd_q[CMD_DATA_POS]
                        && (bit_cnt_q == 5'(CMD_BITS + DATA_BITS - 1));

  // edge detect on the serial clock; inputs are already synchronous
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
    end
  end

  // shift in on rising edges; the count restarts with every frame
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q <= 5'h00;
      sh_in_q <= 8'h00;
      cmd_q <= 8'h00;
    end else if (link.cs_n) begin
      bit_cnt_q <= 5'h00;
    end else if (rise) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      sh_in_q <= in_byte;
      if (cmd_done) begin
        cmd_q <= in_byte;
      end
    end
  end

  // read data loads after the command byte, shifts on later falling edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sh_out_q <= 16'h0000;
    end else if (cmd_done) begin
      sh_out_q <= in_byte[CMD_DATA_POS] ? data_q : {setup_q, 8'h00};
    end else if (fall && !link.cs_n && (bit_cnt_q > 5'(CMD_BITS))) begin
      sh_out_q <= {sh_out_q[14:0], 1'b0};
    end
  end
  assign link.dout = sh_out_q[15];

  // ****************************************
  // gain, output period, correction
  // ****************************************
  logic [1:0] mode;
  logic [1:0] gain_code;
  logic unipolar;
  logic [15:0] period_ticks;
  logic signed [23:0] sample;
  logic signed [23:0] zs_q;
  logic signed [23:0] fs_q;
  logic signed [47:0] diff;
  logic signed [47:0] span;
  logic signed [47:0] scaled;
  logic [15:0] corrected;

  assign mode = {setup_q[MODE_HI_POS], setup_q[MODE_LO_POS]};
  assign gain_code = setup_q[GAIN_POS +: 2];
  assign unipolar = setup_q[UNI_POS];
  assign period_ticks = 16'(RATE_BASE_TICKS) << setup_q[RATE_POS +: 2];
  // every conversion, calibration ones too, sees the selected gain
  assign sample = 24'(analog_input_pair) <<< (32'(gain_code) * GAIN_STEP);

  // offset and slope from the two stored points; a flat or reversed span passes the offset difference
  always_comb begin
    diff = 48'(sample) - 48'(zs_q);
    span = 48'(fs_q) - 48'(zs_q);
    if (span <= 48'sh0) begin
      scaled = diff;
    end else if (unipolar) begin
      scaled = (diff * 48'sd65535) / span;
    end else begin
      scaled = 48'sd32768 + (diff * 48'sd32767) / span;
    end
    if (scaled < 48'sh0) begin
      corrected = 16'h0000;
    end else if (scaled > 48'sd65535) begin
      corrected = 16'hffff;
    end else begin
      corrected = scaled[15:0];
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  seq_t state_q;
  logic self_q;
  logic [15:0] tick_cnt_q;
  logic [3:0] per_left_q;
  logic period_end;
  logic step_last;
  logic publish;
  logic start_cal;
  logic clear_mode;

  assign period_end = mod_tick && (tick_cnt_q == period_ticks - 16'h0001);
  assign step_last = period_end && (per_left_q == 4'h1);
  assign start_cal = wr_done && (in_byte[MODE_HI_POS] || in_byte[MODE_LO_POS]);
  assign publish = period_end && (state_q == S_IDLE) || step_last && (state_q == S_SETTLE);
  assign clear_mode = step_last && ((state_q == S_FULL)
                      || (state_q == S_ZERO && !self_q));
  assign cal_busy = (state_q != S_IDLE);

  // output period counter, restarted when a step begins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 16'h0000;
    end else if (mod_tick) begin
      if (period_end || state_q == S_ARM) begin
        tick_cnt_q <= 16'h0000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
    end
  end

  // step sequencing; a new calibration write restarts the sequence at any time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      self_q <= 1'b0;
      per_left_q <= 4'h0;
    end else if (start_cal) begin
      state_q <= S_ARM;
      self_q <= (in_byte[MODE_HI_POS] == 1'b0);
    end else begin
      case (state_q)
        S_IDLE: begin
          state_q <= S_IDLE;
        end
        S_ARM: begin
          // align to the modulator so the ready line rises within a cycle
          if (mod_tick) begin
            state_q <= (mode == MODE_SYS_FS) ? S_FULL : S_ZERO;
            per_left_q <= 4'(self_q ? SELF_STEP_PERIODS : SYS_STEP_PERIODS);
          end
        end
        S_ZERO: begin
          if (period_end) begin
            per_left_q <= per_left_q - 4'h1;
          end
          if (step_last && self_q) begin
            state_q <= S_FULL;
            per_left_q <= 4'(SELF_STEP_PERIODS);
          end else if (step_last) begin
            state_q <= S_SETTLE;
            per_left_q <= 4'(SYS_SETTLE_PERIODS);
          end
        end
        S_FULL: begin
          if (period_end) begin
            per_left_q <= per_left_q - 4'h1;
          end
          if (step_last) begin
            state_q <= S_SETTLE;
            per_left_q <= 4'(self_q ? SELF_SETTLE_PERIODS : SYS_SETTLE_PERIODS);
          end
        end
        S_SETTLE: begin
          if (period_end) begin
            per_left_q <= per_left_q - 4'h1;
          end
          if (step_last) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // each step writes only its own point; self-cal uses internal points
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      zs_q <= 24'sh000000;
      fs_q <= 24'(FULL_REF);
    end else if (step_last && state_q == S_ZERO) begin
      zs_q <= self_q ? 24'sh000000 : sample;
    end else if (step_last && state_q == S_FULL) begin
      fs_q <= self_q ? 24'(FULL_REF) : sample;
    end
  end

  // setup register; the sequencer clears the mode bits at step end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      setup_q <= SETUP_RST;
    end else if (wr_done) begin
      setup_q <= in_byte;
    end else if (clear_mode) begin
      setup_q[MODE_HI_POS] <= 1'b0;
      setup_q[MODE_LO_POS] <= 1'b0;
    end
  end
  assign setup_word = setup_q;

  // data register takes a word only from a normal conversion
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= 16'h0000;
    end else if (publish) begin
      data_q <= corrected;
    end
  end
  assign result_word = data_q;

  // ready line: high through a calibration, low on a fresh word
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link.result_ready_n <= 1'b1;
    end else if (state_q == S_ARM && mod_tick) begin
      link.result_ready_n <= 1'b1;
    end else if (publish) begin
      link.result_ready_n <= 1'b0;
    end else if (rd_data_done) begin
      link.result_ready_n <= 1'b1;
    end
  end
endmodule // sdcal_device

/* hw/sdcal_host.sv */
// controller end: register port for software, serial master, ready watch
// assumes a single-cycle software port and the device on the other link end
module sdcal_host #(
  parameter int SCLK_HALF = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // link to the device
  cal_link_if.ctl link
);
  import sdcal_pkg::*;

  typedef enum {H_IDLE, H_XFER} hstate_t;

  // ****************************************
  // command decode
  // ****************************************
  hstate_t state_q;
  logic [1:0] op;
  logic [1:0] new_mode;
  logic ctrl_wr;
  logic seq_bad;
  logic go;
  logic xfer_end;
  logic zs_done_q;

  assign op = reg_wdata[OP_POS +: 2];
  assign new_mode = {reg_wdata[MODE_HI_POS], reg_wdata[MODE_LO_POS]};
  assign ctrl_wr = reg_wr && (reg_addr == REG_CTRL) && (state_q == H_IDLE);
  // a full-scale step before any zero-scale step is refused
  assign seq_bad = ctrl_wr && (op == OP_WR_SETUP) && (new_mode == MODE_SYS_FS)
                   && !zs_done_q;
  assign go = ctrl_wr && !seq_bad;

  // ****************************************
  // serial master
  // ****************************************
  logic [7:0] half_q;
  logic sclk_q;
  logic [4:0] bits_q;
  logic [4:0] nbits_q;
  logic [23:0] tx_q;
  logic [15:0] rx_q;
  logic cal_cmd_q;
  logic half_end;

  assign half_end = (half_q == 8'(SCLK_HALF - 1));
  assign xfer_end = (state_q == H_XFER) && half_end && sclk_q && (bits_q == nbits_q);

  // frame: idle low clock, data set before each rising edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= H_IDLE;
      half_q <= 8'h00;
      sclk_q <= 1'b0;
      bits_q <= 5'h00;
      nbits_q <= 5'h00;
      tx_q <= 24'h000000;
      rx_q <= 16'h0000;
      cal_cmd_q <= 1'b0;
    end else if (state_q == H_IDLE) begin
      half_q <= 8'h00;
      sclk_q <= 1'b0;
      bits_q <= 5'h00;
      if (go) begin
        state_q <= H_XFER;
        tx_q <= {op == OP_RD_DATA ? 8'hc0 : (op == OP_RD_SETUP ? 8'h80 : 8'h00),
                 reg_wdata[7:0], 8'h00};
        nbits_q <= 5'(op == OP_RD_DATA ? CMD_BITS + DATA_BITS : CMD_BITS + SETUP_BITS);
        cal_cmd_q <= (op == OP_WR_SETUP) && (new_mode != MODE_NORMAL);
      end
    end else if (half_end) begin
      half_q <= 8'h00;
      sclk_q <= !sclk_q;
      if (!sclk_q) begin
        bits_q <= bits_q + 5'h01;
        rx_q <= {rx_q[14:0], link.dout};
      end else if (bits_q == nbits_q) begin
        state_q <= H_IDLE;
      end else begin
        tx_q <= {tx_q[22:0], 1'b0};
      end
    end else begin
      half_q <= half_q + 8'h01;
    end
  end
  assign link.cs_n = (state_q == H_IDLE);
  assign link.sclk = sclk_q;
  assign link.din = tx_q[23];

  // ****************************************
  // ready watch after a calibration command
  // ****************************************
  logic [7:0] blank_q;
  logic ready_seen;
  logic ready_seen_q;
  // the device may need a modulator cycle before it raises the line
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      blank_q <= 8'h00;
    end else if (xfer_end && cal_cmd_q) begin
      blank_q <= 8'(MOD_CYCLE_CLKS);
    end else if (blank_q != 8'h00) begin
      blank_q <= blank_q - 8'h01;
    end
  end
  assign ready_seen = !link.result_ready_n && (blank_q == 8'h00) && (state_q == H_IDLE);

  // zero-scale step seen, so a full-scale step may follow
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      zs_done_q <= 1'b0;
      ready_seen_q <= 1'b0;
    end else begin
      ready_seen_q <= ready_seen;
      if (go && op == OP_WR_SETUP && new_mode == MODE_SYS_ZS) begin
        zs_done_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // status, mask, read port
  // ****************************************
  logic [2:0] st_q;
  logic [2:0] mask_q;
  logic [2:0] ev;
  logic [2:0] clr;
  logic [15:0] rdata_hold_q;
  assign ev = {seq_bad, ready_seen && !ready_seen_q, xfer_end};
  assign clr = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[2:0] : 3'h0;

  // sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= 3'h0;
      mask_q <= MASK_RST;
      rdata_hold_q <= 16'h0000;
    end else begin
      st_q <= (st_q & ~clr) | ev;
      if (reg_wr && reg_addr == REG_MASK) begin
        mask_q <= reg_wdata[2:0];
      end
      if (xfer_end) begin
        rdata_hold_q <= (nbits_q == 5'(CMD_BITS + DATA_BITS)) ? rx_q : {8'h00, rx_q[7:0]};
      end
    end
  end
  assign irq = |(st_q & mask_q);

  // read data stand one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: reg_rdata <= {21'h0, !link.result_ready_n, zs_done_q,
                                  state_q == H_XFER, 5'h00, st_q};
        REG_MASK: reg_rdata <= {29'h0, mask_q};
        REG_RDATA: reg_rdata <= {16'h0000, rdata_hold_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule // sdcal_host

/* verif/sdcal_link_properties.sv */
// checker for the link between host and device ends
// assumes one clk_sys domain; instantiated beside the interface
module sdcal_link_props #(
  parameter int PERIOD_CLKS = 256
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic result_ready_n
);
  import sdcal_pkg::*;
  // ****************************************
  // frame decode
  // ****************************************
  logic sclk_q, cs_q, act_q, zs_seen_q, cal_cmd;
  logic [4:0] nb_q;
  logic [15:0] sh_q;
  logic [1:0] md_q;
  int cnt_q, lo, hi;
  // count rises and shift din; din is steady while sclk is high
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      nb_q <= '0;
      sh_q <= '0;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      if (cs_n) nb_q <= '0;
      else if (sclk && !sclk_q) begin
        nb_q <= nb_q + 5'h1;
        sh_q <= {sh_q[14:0], din};
      end
    end
  end
  // a finished setup write with a calibration code
  assign cal_cmd = cs_n && !cs_q && nb_q == 5'h10 && sh_q[15:14] == 2'h0 && sh_q[7:6] != 2'h0;
  // time since the command; closed when ready falls after the rise window
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act_q <= 1'b0;
      cnt_q <= 0;
      md_q <= MODE_NORMAL;
      zs_seen_q <= 1'b0;
    end else if (cal_cmd) begin
      act_q <= 1'b1;
      cnt_q <= 0;
      md_q <= sh_q[7:6];
      if (sh_q[7:6] == MODE_SYS_ZS) zs_seen_q <= 1'b1;
    end else if (act_q) begin
      cnt_q <= cnt_q + 1;
      if (cnt_q > 136 && !result_ready_n) act_q <= 1'b0;
    end
  end
  // slack covers the modulator-cycle start and the last sclk half
  assign lo = (md_q == MODE_SELF ? SELF_STEP_PERIODS * 2 + SELF_SETTLE_PERIODS :
    SYS_STEP_PERIODS + SYS_SETTLE_PERIODS) * PERIOD_CLKS - 16;
  assign hi = lo + 176;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("sclk not low outside a frame");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high half of wrong length");
  AST_DIN_HELD: assert property (sclk && !$rose(sclk) |-> $stable(din))
    else $error("din moved while sclk high");
  AST_FRAME_GAP: assert property ($rose(cs_n) |=> cs_n)
    else $error("no idle cycle between frames");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> nb_q == 5'h10 || nb_q == 5'h18)
    else $error("frame of wrong bit count");
  AST_FS_ORDER: assert property (cal_cmd && sh_q[7:6] == MODE_SYS_FS |-> zs_seen_q)
    else $error("full step sent before any zero step");
  AST_READY_RISE: assert property (cal_cmd |-> ##[0:136] result_ready_n)
    else $error("ready not high within one modulator cycle");
  AST_READY_HELD: assert property (act_q && cnt_q > 136 && cnt_q < lo |-> result_ready_n)
    else $error("ready low before calibration result");
  AST_READY_DEADLINE: assert property (act_q |-> cnt_q <= hi)
    else $error("ready late after calibration command");
  COV_ZS: cover property (cal_cmd && sh_q[7:6] == MODE_SYS_ZS);
  COV_FS: cover property (cal_cmd && sh_q[7:6] == MODE_SYS_FS);
  COV_SELF: cover property (cal_cmd && sh_q[7:6] == MODE_SELF);
endmodule // sdcal_link_props

/* verif/sigma_delta_calibration_sequencer_tb_top.sv */
// testbench: host and device ends joined by the link, driven over the register port
// assumes rate code 0 and RATE_BASE_TICKS 2, so one output period is 256 clocks
module sigma_delta_calibration_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdcal_pkg::*;
  localparam int P = 2 * MOD_CYCLE_CLKS;
  logic clk_sys, rst_b, reg_wr, reg_rd, irq, cal_busy;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic signed [15:0] analog_input_pair;
  logic [7:0] setup_word;
  logic [15:0] result_word;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // ****************************************
  // ends, link and checker
  // ****************************************
  cal_link_if cal_link_if_i ();
  sdcal_device #(.RATE_BASE_TICKS(2)) sdcal_device_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .link(cal_link_if_i.dev), .analog_input_pair(analog_input_pair),
    .setup_word(setup_word), .result_word(result_word), .cal_busy(cal_busy));
  sdcal_host #(.SCLK_HALF(4)) sdcal_host_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .link(cal_link_if_i.ctl));
  sdcal_link_props #(.PERIOD_CLKS(P)) sdcal_link_props_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .cs_n(cal_link_if_i.cs_n), .sclk(cal_link_if_i.sclk), .din(cal_link_if_i.din),
    .dout(cal_link_if_i.dout), .result_ready_n(cal_link_if_i.result_ready_n));
  // ****************************************
  // tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  // poll a sticky flag, bounded, then clear it by writing one
  task automatic wait_st(input int b);
    logic [31:0] s = '0;
    for (int n = 0; n < 3000 && s[b] !== 1'b1; n++) rd(REG_STATUS, s);
    chk("status flag", s[b], 1'b1);
    wr(REG_STATUS, 32'h1 << b);
  endtask
  // one setup write, then the mode-clear time and the first result after it
  task automatic run(input logic [7:0] su, input logic signed [15:0] x, input int steps,
    input logic [15:0] exp);
    int n;
    logic [31:0] d;
    analog_input_pair <= x;
    wr(REG_CTRL, {24'h0, su});
    wait_st(ST_XFER_DONE);
    for (n = 0; n < 4000 && setup_word[7:6] !== MODE_NORMAL; n++) @(posedge clk_sys);
    chk("mode clear time", 32'(n >= steps * P - 32 && n <= steps * P + 136), 32'h1);
    chk("setup after step", setup_word, {2'h0, su[5:0]});
    if (steps == 0) chk("busy in normal", cal_busy, 1'b0);
    wr(REG_STATUS, 32'h1 << ST_RESULT);
    // a read frame lifts a ready line left low, so a fresh word makes a new edge
    if (steps == 0) begin
      wr(REG_CTRL, {22'h0, OP_RD_DATA, 8'h00});
      wait_st(ST_XFER_DONE);
    end
    wait_st(ST_RESULT);
    wr(REG_CTRL, {22'h0, OP_RD_DATA, 8'h00});
    wait_st(ST_XFER_DONE);
    rd(REG_RDATA, d);
    chk("result", d[15:0], exp);
    chk("result word", result_word, exp);
  endtask
  // ****************************************
  // clock, timeout, sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // whole run is near 10000 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    analog_input_pair = 16'sd0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("setup reset", setup_word, SETUP_RST);
    rd(REG_STATUS, v);
    chk("status reset", v[2:0], 3'h0);
    rd(REG_MASK, v);
    chk("mask reset", v, {29'h0, MASK_RST});
    rd(4'hf, v);
    chk("unmapped", v, 32'h0);
    // full step before any zero step is refused
    wr(REG_CTRL, 32'h0d0);
    rd(REG_STATUS, v);
    chk("sequence error", v[2:0], 3'h4);
    chk("irq masked", irq, 1'b0);
    wr(REG_MASK, 32'h4);
    @(posedge clk_sys);
    chk("irq raised", irq, 1'b1);
    wr(REG_STATUS, 32'h4);
    @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    wr(REG_MASK, 32'h0);
    // gain code 1 throughout; results are bipolar except the unipolar 8'h18 run
    run(8'h90, 16'sd100, 3, 16'd32768);
    run(8'hd0, 16'sd8100, 3, 16'd65535);
    run(8'h10, 16'sd4100, 0, 16'd49151);
    run(8'h90, 16'sd2100, 3, 16'd32768);
    run(8'h10, 16'sd3600, 0, 16'd40959);
    run(8'h18, 16'sd4100, 0, 16'd21845);
    run(8'h50, 16'sd0, 6, 16'd32768);
    end_sim();
  end
endmodule // sigma_delta_calibration_sequencer_tb_top
